// [src/cpmc_top.sv]
/*
 * Clock path mode configuration: PLL power, source select, VCO divider, PFD polarity,
 * reference enables, calibration trigger and power-up restore from nonvolatile memory.
 * Assumes a synchronous 8-bit register port and an external nonvolatile store that
 * presents one byte per valid pulse when asked, held steady while that pulse crosses.
 */
// How it works
// - Power field 00b runs the PLL, 01b powers it down asynchronously.
// - Source bit 1b routes the internal VCO, 0b the external clock input.
// - Bypass bit 0b uses the VCO divider, 1b passes source straight through.
// - Reset leaves PLL down, divider code 000b, divider used, external source.
// - Calibration bit set then transfer strobe starts one VCO calibration; the next one needs a transfer with the bit clear first.
// - Polarity bit 0b positive, 1b negative tuning slope.
// - External source with PLL on powers off the internal VCO.
// - Three enable bits turn reference inputs on one by one.
// - Stored values are restored from nonvolatile memory at power-up.
// - Default routing accepts up to 2400 MHz, divided before channel dividers.
`timescale 1ns/10ps
`default_nettype none
`include "cpmc_map.svh"
module cpmc_top
    import cpmc_pkg::*;
(
    // Clock and reset
    input  wire logic                    sys_clk_i,
    input  wire logic                    rst_i,
    // Register port
    input  wire logic                    reg_wr_i,
    input  wire logic                    reg_rd_i,
    input  wire logic [`CPMC_AW-1:0]     reg_addr_i,
    input  wire logic [`CPMC_DW-1:0]     reg_wdata_i,
    output logic      [`CPMC_DW-1:0]     reg_rdata_o,
    // Nonvolatile restore port
    input  wire logic                    nvm_valid_i,
    input  wire logic [`CPMC_AW-1:0]     nvm_addr_i,
    input  wire logic [`CPMC_DW-1:0]     nvm_data_i,
    input  wire logic                    nvm_done_i,
    output logic                         nvm_load_o,
    // Clock path controls
    output logic                         pll_power_down_o,
    output logic                         vco_power_down_o,
    output logic                         vco_source_sel_o,
    output logic                         vco_div_bypass_o,
    output logic      [`CPMC_RATIO_W-1:0] vco_div_ratio_o,
    output logic                         pfd_negative_o,
    output logic      [`CPMC_REF_MSB:0]  ref_enable_o,
    output logic                         vco_cal_start_o,
    output logic                         vco_cal_busy_o,
    input  wire logic                    vco_cal_done_i
);
    localparam int NREG = 5;

    logic                nvm_load;
    logic                nvm_valid_s1;
    logic                nvm_valid_s2;
    logic                nvm_done_s1;
    logic                nvm_done_s2;
    logic [`CPMC_AW-1:0] nvm_addr_s1;
    logic [`CPMC_AW-1:0] nvm_addr_s2;
    logic [`CPMC_DW-1:0] nvm_data_s1;
    logic [`CPMC_DW-1:0] nvm_data_s2;
    logic                cal_done_s1;
    logic                cal_done_s2;
    logic [`CPMC_DW-1:0] xfer_reg;
    cpmc_cal_e           cal_state;
    cpmc_cal_e           next_cal_state;

    // The restore bus replaces the host port while the load runs, so the two never race.
    wire                 any_wr  = nvm_load ? nvm_valid_s2 : reg_wr_i;
    wire [`CPMC_AW-1:0]  wr_addr = nvm_load ? nvm_addr_s2 : reg_addr_i;
    wire [`CPMC_DW-1:0]  wr_data = nvm_load ? nvm_data_s2 : reg_wdata_i;
    wire                 hit_xfer = any_wr && (wr_addr == `CPMC_OFF_XFER);
    wire                 xfer     = hit_xfer && wr_data[`CPMC_XFER_BIT];

    wire [`CPMC_AW-1:0]  offs [NREG] = '{`CPMC_OFF_PWR_POL, `CPMC_OFF_VCO_CAL,
                                         `CPMC_OFF_REF_EN, `CPMC_OFF_VCO_DIV,
                                         `CPMC_OFF_SRC_SEL};
    logic [`CPMC_DW-1:0] staged [NREG];
    logic [`CPMC_DW-1:0] active [NREG];

    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++) begin : g_reg
            cpmc_cfg_reg #(
                .RESET_VALUE ((gi == 0) ? `CPMC_RST_PWR_POL : `CPMC_RST_ZERO)
            ) u_reg (
                .sys_clk_i (sys_clk_i),
                .rst_i     (rst_i),
                .wr_i      (any_wr && (wr_addr == offs[gi])),
                .wdata_i   (wr_data),
                .xfer_i    (xfer),
                .staged_o  (staged[gi]),
                .active_o  (active[gi])
            );
        end
    endgenerate

    // Restore signals come from another domain and pass two flip-flops.
    // The store holds address and data steady while its strobe crosses, so both copies settle together.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            nvm_addr_s1  <= '0;
            nvm_addr_s2  <= '0;
            nvm_data_s1  <= `CPMC_RST_ZERO;
            nvm_data_s2  <= `CPMC_RST_ZERO;
            nvm_valid_s1 <= 1'b0;
            nvm_valid_s2 <= 1'b0;
            nvm_done_s1  <= 1'b0;
            nvm_done_s2  <= 1'b0;
            cal_done_s1  <= 1'b0;
            cal_done_s2  <= 1'b0;
        end else begin
            nvm_addr_s1  <= nvm_addr_i;
            nvm_addr_s2  <= nvm_addr_s1;
            nvm_data_s1  <= nvm_data_i;
            nvm_data_s2  <= nvm_data_s1;
            nvm_valid_s1 <= nvm_valid_i;
            nvm_valid_s2 <= nvm_valid_s1;
            nvm_done_s1  <= nvm_done_i;
            nvm_done_s2  <= nvm_done_s1;
            cal_done_s1  <= vco_cal_done_i;
            cal_done_s2  <= cal_done_s1;
        end
    end

    // Restore runs once after every reset, ending when the store reports done.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            nvm_load <= 1'b1;
        end else if (nvm_done_s2) begin
            nvm_load <= 1'b0;
        end
    end
    assign nvm_load_o = nvm_load;

    // The strobe register is self-clearing so a later write is seen as a new event.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            xfer_reg <= `CPMC_RST_ZERO;
        end else if (hit_xfer) begin
            xfer_reg <= wr_data & ~(`CPMC_DW'(1) << `CPMC_XFER_BIT);
        end
    end

    // Calibration: armed by the bit, fired by the strobe, re-armed only after a cleared transfer.
    wire cal_req = xfer && wr_data[`CPMC_XFER_BIT] &&
                   ((wr_addr == `CPMC_OFF_VCO_CAL) ? wr_data[`CPMC_CAL_BIT] : staged[1][`CPMC_CAL_BIT]);
    wire cal_clr = xfer && !((wr_addr == `CPMC_OFF_VCO_CAL) ? wr_data[`CPMC_CAL_BIT] : staged[1][`CPMC_CAL_BIT]);

    always_comb begin
        next_cal_state = cal_state;
        case (cal_state)
            CPMC_CAL_IDLE:  if (cal_req) next_cal_state = CPMC_CAL_RUN;
            CPMC_CAL_RUN:   if (cal_done_s2) next_cal_state = CPMC_CAL_SPENT;
            CPMC_CAL_SPENT: if (cal_clr) next_cal_state = CPMC_CAL_IDLE;
            default:        next_cal_state = CPMC_CAL_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cal_state <= CPMC_CAL_IDLE;
        end else begin
            cal_state <= next_cal_state;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            vco_cal_start_o <= 1'b0;
        end else begin
            vco_cal_start_o <= (cal_state == CPMC_CAL_IDLE) && cal_req;
        end
    end
    assign vco_cal_busy_o = (cal_state == CPMC_CAL_RUN);

    // Clock path decode from the active copies.
    wire [1:0] pwr_fld = active[0][`CPMC_PWR_MSB:`CPMC_PWR_LSB];
    wire [2:0] div_fld = active[3][`CPMC_DIV_MSB:0];

    assign pll_power_down_o = (pwr_fld != `CPMC_PWR_NORMAL);
    assign pfd_negative_o   = active[0][`CPMC_POL_BIT];
    assign ref_enable_o     = active[2][`CPMC_REF_MSB:0];
    assign vco_source_sel_o = active[4][`CPMC_VCO_SEL_BIT];
    assign vco_div_bypass_o = active[4][`CPMC_BYP_BIT];
    // The internal VCO runs only when it is the selected source and the PLL is on.
    assign vco_power_down_o = !vco_source_sel_o || pll_power_down_o;

    // Unused codes fall back to divide-by-two, the safe default ratio.
    always_comb begin
        if (div_fld == `CPMC_CODE_DIV3) begin
            vco_div_ratio_o = `CPMC_RATIO_THREE;
        end else if (div_fld == `CPMC_CODE_DIV4) begin
            vco_div_ratio_o = `CPMC_RATIO_FOUR;
        end else if (div_fld == `CPMC_CODE_DIV5) begin
            vco_div_ratio_o = `CPMC_RATIO_FIVE;
        end else if (div_fld == `CPMC_CODE_DIV6) begin
            vco_div_ratio_o = `CPMC_RATIO_SIX;
        end else if (div_fld == `CPMC_CODE_DIV1) begin
            vco_div_ratio_o = `CPMC_RATIO_ONE;
        end else begin
            vco_div_ratio_o = `CPMC_RATIO_TWO;
        end
    end

    // Reads return the staged value, or the strobe register at the transfer address; unmapped addresses read zero.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= `CPMC_RST_ZERO;
        end else if (reg_rd_i) begin
            if (reg_addr_i == `CPMC_OFF_PWR_POL) begin
                reg_rdata_o <= staged[0];
            end else if (reg_addr_i == `CPMC_OFF_VCO_CAL) begin
                reg_rdata_o <= staged[1];
            end else if (reg_addr_i == `CPMC_OFF_REF_EN) begin
                reg_rdata_o <= staged[2];
            end else if (reg_addr_i == `CPMC_OFF_VCO_DIV) begin
                reg_rdata_o <= staged[3];
            end else if (reg_addr_i == `CPMC_OFF_SRC_SEL) begin
                reg_rdata_o <= staged[4];
            end else if (reg_addr_i == `CPMC_OFF_XFER) begin
                reg_rdata_o <= xfer_reg;
            end else begin
                reg_rdata_o <= `CPMC_RST_ZERO;
            end
        end
    end
endmodule : cpmc_top
`default_nettype wire

// [src/cpmc_map.svh]
/*
 * Register offsets, field positions, reset values and codes for the clock path mode block.
 * Assumes a register port with a 10-bit address and 8-bit data.
 */
`ifndef CPMC_MAP_SVH
`define CPMC_MAP_SVH
`define CPMC_AW                 10
`define CPMC_DW                 8
`define CPMC_OFF_PWR_POL        10'h010
`define CPMC_OFF_VCO_CAL        10'h018
`define CPMC_OFF_REF_EN         10'h01c
`define CPMC_OFF_VCO_DIV        10'h1e0
`define CPMC_OFF_SRC_SEL        10'h1e1
`define CPMC_OFF_XFER           10'h232
`define CPMC_PWR_LSB            0
`define CPMC_PWR_MSB            1
`define CPMC_POL_BIT            7
`define CPMC_CAL_BIT            0
`define CPMC_REF_MSB            2
`define CPMC_DIV_MSB            2
`define CPMC_BYP_BIT            0
`define CPMC_VCO_SEL_BIT        1
`define CPMC_XFER_BIT           0
`define CPMC_PWR_NORMAL         2'h0
`define CPMC_PWR_DOWN           2'h1
`define CPMC_RST_PWR_POL        8'h01
`define CPMC_RST_ZERO           8'h00
`define CPMC_RATIO_W            3
`define CPMC_RATIO_ONE          3'h1
`define CPMC_RATIO_TWO          3'h2
`define CPMC_RATIO_THREE        3'h3
`define CPMC_RATIO_FOUR         3'h4
`define CPMC_RATIO_FIVE         3'h5
`define CPMC_RATIO_SIX          3'h6
`define CPMC_CODE_DIV2          3'h0
`define CPMC_CODE_DIV3          3'h1
`define CPMC_CODE_DIV4          3'h2
`define CPMC_CODE_DIV5          3'h3
`define CPMC_CODE_DIV6          3'h4
`define CPMC_CODE_DIV1          3'h5
`endif

// [src/cpmc_pkg.sv]
/*
 * Types shared by the clock path mode block.
 * Assumes cpmc_map.svh is compiled alongside.
 */
package cpmc_pkg;
    typedef enum logic [2:0] {
        CPMC_CAL_IDLE  = 3'b001,
        CPMC_CAL_RUN   = 3'b010,
        CPMC_CAL_SPENT = 3'b100
    } cpmc_cal_e;
endpackage : cpmc_pkg

// [src/cpmc_cfg_reg.sv]
/*
 * One 8-bit control register with a staged copy and an active copy.
 * Assumes write strobes and the transfer strobe come from the same clock domain.
 */
`timescale 1ns/10ps
`default_nettype none
`include "cpmc_map.svh"
module cpmc_cfg_reg
    import cpmc_pkg::*;
#(
    parameter logic [`CPMC_DW-1:0] RESET_VALUE = `CPMC_RST_ZERO
) (
    // Clock and reset
    input  wire logic                sys_clk_i,
    input  wire logic                rst_i,
    // Staging write and transfer
    input  wire logic                wr_i,
    input  wire logic [`CPMC_DW-1:0] wdata_i,
    input  wire logic                xfer_i,
    // Copies
    output logic      [`CPMC_DW-1:0] staged_o,
    output logic      [`CPMC_DW-1:0] active_o
);
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            staged_o <= RESET_VALUE;
        end else if (wr_i) begin
            staged_o <= wdata_i;
        end
    end

    // A write landing with the transfer strobe is taken into the active copy at once.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            active_o <= RESET_VALUE;
        end else if (xfer_i) begin
            active_o <= wr_i ? wdata_i : staged_o;
        end
    end
endmodule : cpmc_cfg_reg
`default_nettype wire

// [tb/cpmc_cal_model.sv]
/*
 * Behavioural calibrator that answers calibration start pulses of the clock path block.
 * Assumes the same clock and reset as the block under test.
 */
`timescale 1ns/10ps
`default_nettype none
module cpmc_cal_model #(
    parameter int DLY = 5
) (
    // Clock, reset and calibration handshake
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    input  wire logic start_i,
    input  wire logic busy_i,
    output logic      done_o
);
    int cnt;
    // Done is held until busy drops, so the slow synchroniser never misses it.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= 0;
            done_o <= 1'b0;
        end else if (start_i) begin
            cnt <= DLY;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end else if (cnt == 1) begin
            cnt <= 0;
            done_o <= 1'b1;
        end else if (!busy_i) begin
            done_o <= 1'b0;
        end
    end
endmodule : cpmc_cal_model
`default_nettype wire

// [tb/cpmc_top_asserts.sv]
/*
 * Concurrent checks on the ports of the clock path block.
 * Assumes one clock domain and the register map header.
 */
`timescale 1ns/10ps
`default_nettype none
`include "cpmc_map.svh"
module cpmc_top_asserts (
    // Watched ports
    input wire logic                     sys_clk_i,
    input wire logic                     rst_i,
    input wire logic                     reg_wr_i,
    input wire logic                     reg_rd_i,
    input wire logic [`CPMC_AW-1:0]      reg_addr_i,
    input wire logic [`CPMC_DW-1:0]      reg_wdata_i,
    input wire logic [`CPMC_DW-1:0]      reg_rdata_o,
    input wire logic                     nvm_load_o,
    input wire logic                     pll_power_down_o,
    input wire logic                     vco_power_down_o,
    input wire logic                     vco_source_sel_o,
    input wire logic                     vco_div_bypass_o,
    input wire logic [`CPMC_RATIO_W-1:0] vco_div_ratio_o,
    input wire logic                     pfd_negative_o,
    input wire logic [`CPMC_REF_MSB:0]   ref_enable_o,
    input wire logic                     vco_cal_start_o,
    input wire logic                     vco_cal_busy_o,
    input wire logic                     vco_cal_done_i
);
    wire xw = reg_wr_i && reg_addr_i == `CPMC_OFF_XFER && reg_wdata_i[0];
    wire hit = reg_addr_i inside {`CPMC_OFF_PWR_POL, `CPMC_OFF_VCO_CAL, `CPMC_OFF_REF_EN,
                                  `CPMC_OFF_VCO_DIV, `CPMC_OFF_SRC_SEL, `CPMC_OFF_XFER};
    wire [9:0] cfg = {pll_power_down_o, vco_source_sel_o, vco_div_bypass_o,
                      vco_div_ratio_o, pfd_negative_o, ref_enable_o};
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_cal_go;
        vco_cal_start_o && vco_cal_busy_o;
    endsequence
    property p_vco_off; vco_power_down_o == (!vco_source_sel_o || pll_power_down_o); endproperty
    a_vco_off: assert property (p_vco_off) else $error("vco power state wrong");
    property p_hold; $changed(cfg) && !nvm_load_o && !$past(nvm_load_o) |-> $past(xw); endproperty
    a_hold: assert property (p_hold) else $error("config changed without transfer");
    property p_start; vco_cal_start_o && !$past(nvm_load_o) |-> $past(xw); endproperty
    a_start: assert property (p_start) else $error("start without transfer");
    property p_pulse; s_cal_go |=> !vco_cal_start_o && vco_cal_busy_o; endproperty
    a_pulse: assert property (p_pulse) else $error("start not a single pulse");
    property p_busy_rise; $rose(vco_cal_busy_o) |-> vco_cal_start_o; endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy without start");
    property p_busy_end; $fell(vco_cal_busy_o) |-> $past(vco_cal_done_i, 2) || $past(vco_cal_done_i, 3); endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy ended without done");
    property p_reset;
        $fell(rst_i) |-> pll_power_down_o && !vco_source_sel_o && !vco_div_bypass_o
            && vco_div_ratio_o == `CPMC_RATIO_TWO;
    endproperty
    a_reset: assert property (p_reset) else $error("reset defaults wrong");
    property p_ratio; vco_div_ratio_o inside {[3'h1:3'h6]}; endproperty
    a_ratio: assert property (p_ratio) else $error("ratio out of range");
    property p_unmapped; reg_rd_i && !hit |=> reg_rdata_o == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : cpmc_top_asserts
bind cpmc_top cpmc_top_asserts u_asserts (.sys_clk_i, .rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .nvm_load_o, .pll_power_down_o, .vco_power_down_o, .vco_source_sel_o,
    .vco_div_bypass_o, .vco_div_ratio_o, .pfd_negative_o, .ref_enable_o, .vco_cal_start_o,
    .vco_cal_busy_o, .vco_cal_done_i);
`default_nettype wire

// [tb/tb_clock_path_mode_config.sv]
/*
 * Self-checking testbench for the clock path block: restore, staging, divider table, calibration.
 * Assumes the calibration model answers start pulses.
 */
`timescale 1ns/10ps
`default_nettype none
`include "cpmc_map.svh"
`define CHK(n,e,g) begin comparisons++; if ((g)!==(e)) begin err_total++; $display("Error %s exp %h got %h",n,e,g); end end
module tb_clock_path_mode_config;
    logic sys_clk_i, rst_i, reg_wr_i, reg_rd_i, nvm_valid_i, nvm_done_i, nvm_load_o;
    logic [`CPMC_AW-1:0] reg_addr_i, nvm_addr_i;
    logic [7:0] reg_wdata_i, nvm_data_i, reg_rdata_o;
    logic pll_power_down_o, vco_power_down_o, vco_source_sel_o, vco_div_bypass_o;
    logic pfd_negative_o, vco_cal_start_o, vco_cal_busy_o, vco_cal_done_i;
    logic [2:0] vco_div_ratio_o, ref_enable_o;
    logic [2:0] rtab [8] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h1, 3'h2, 3'h2};
    int err_total, comparisons, i, n;
    cpmc_top uut (.sys_clk_i, .rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
        .nvm_valid_i, .nvm_addr_i, .nvm_data_i, .nvm_done_i, .nvm_load_o, .pll_power_down_o,
        .vco_power_down_o, .vco_source_sel_o, .vco_div_bypass_o, .vco_div_ratio_o, .pfd_negative_o,
        .ref_enable_o, .vco_cal_start_o, .vco_cal_busy_o, .vco_cal_done_i);
    cpmc_cal_model u_cal (.sys_clk_i, .rst_i, .start_i(vco_cal_start_o), .busy_i(vco_cal_busy_o),
        .done_o(vco_cal_done_i));
    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk_i);
        #1;
    endtask : cyc
    task automatic wr(input logic [`CPMC_AW-1:0] a, input logic [7:0] d);
        cyc(1);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        cyc(1);
        reg_wr_i = 1'b0;
    endtask : wr
    task automatic rd(input logic [`CPMC_AW-1:0] a, input logic [7:0] e);
        cyc(1);
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        cyc(1);
        reg_rd_i = 1'b0;
        `CHK("rdata", e, reg_rdata_o)
    endtask : rd
    // Restore bytes must stay put while the valid pulse crosses the synchroniser.
    task automatic nv(input logic [`CPMC_AW-1:0] a, input logic [7:0] d);
        nvm_addr_i = a;
        nvm_data_i = d;
        nvm_valid_i = 1'b1;
        cyc(1);
        nvm_valid_i = 1'b0;
        cyc(4);
    endtask : nv
    task automatic cal(input logic e);
        wr(`CPMC_OFF_VCO_CAL, 8'h01);
        wr(`CPMC_OFF_XFER, 8'h01);
        for (n = 0; n < 3 && vco_cal_start_o !== 1'b1; n++) cyc(1);
        `CHK("cal_start", e, vco_cal_start_o)
        for (n = 0; n < 50 && vco_cal_busy_o !== 1'b0; n++) cyc(1);
        `CHK("cal_busy", 1'b0, vco_cal_busy_o)
    endtask : cal
    task automatic test_done;
        $display("Comparisons %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : test_done
    initial begin
        {rst_i, reg_wr_i, reg_rd_i, nvm_valid_i, nvm_done_i} = 5'h10;
        {reg_addr_i, nvm_addr_i, reg_wdata_i, nvm_data_i} = '0;
        cyc(8);
        rst_i = 1'b0;
        `CHK("pll_pd", 1'b1, pll_power_down_o)
        `CHK("ratio", 3'h2, vco_div_ratio_o)
        `CHK("sel_byp", 2'h0, {vco_source_sel_o, vco_div_bypass_o})
        nv(`CPMC_OFF_VCO_DIV, 8'h03);
        nv(`CPMC_OFF_XFER, 8'h01);
        wr(`CPMC_OFF_REF_EN, 8'h07);
        nvm_done_i = 1'b1;
        for (n = 0; n < 20 && nvm_load_o !== 1'b0; n++) cyc(1);
        `CHK("nvm_load", 1'b0, nvm_load_o)
        `CHK("ratio", 3'h5, vco_div_ratio_o)
        rd(`CPMC_OFF_REF_EN, 8'h00);
        rd(`CPMC_OFF_PWR_POL, 8'h01);
        wr(`CPMC_OFF_SRC_SEL, 8'h02);
        `CHK("sel", 1'b0, vco_source_sel_o)
        rd(`CPMC_OFF_SRC_SEL, 8'h02);
        wr(`CPMC_OFF_XFER, 8'h01);
        `CHK("sel", 1'b1, vco_source_sel_o)
        `CHK("vco_pd", 1'b1, vco_power_down_o)
        rd(`CPMC_OFF_XFER, 8'h00);
        wr(`CPMC_OFF_PWR_POL, 8'h80);
        wr(`CPMC_OFF_XFER, 8'h01);
        `CHK("pll_pd", 1'b0, pll_power_down_o)
        `CHK("pfd_neg", 1'b1, pfd_negative_o)
        `CHK("vco_pd", 1'b0, vco_power_down_o)
        for (i = 0; i < 8; i++) begin
            wr(`CPMC_OFF_VCO_DIV, 8'hf8 | 8'(i));
            wr(`CPMC_OFF_SRC_SEL, 8'(i & 1));
            wr(`CPMC_OFF_XFER, 8'h01);
            `CHK("ratio", rtab[i], vco_div_ratio_o)
            `CHK("bypass", 1'(i & 1), vco_div_bypass_o)
            `CHK("vco_pd", 1'b1, vco_power_down_o)
            rd(`CPMC_OFF_VCO_DIV, 8'hf8 | 8'(i));
        end
        for (i = 0; i < 3; i++) begin
            wr(`CPMC_OFF_REF_EN, 8'(1 << i));
            wr(`CPMC_OFF_XFER, 8'h01);
            `CHK("ref_en", 3'(1 << i), ref_enable_o)
        end
        wr(`CPMC_OFF_PWR_POL, 8'h03);
        wr(`CPMC_OFF_XFER, 8'h01);
        `CHK("pll_pd", 1'b1, pll_power_down_o)
        wr(`CPMC_OFF_PWR_POL, 8'h01);
        wr(`CPMC_OFF_XFER, 8'h01);
        `CHK("pll_pd", 1'b1, pll_power_down_o)
        wr(10'h3ff, 8'hff);
        rd(10'h3ff, 8'h00);
        cal(1'b1);
        cal(1'b0);
        wr(`CPMC_OFF_VCO_CAL, 8'h00);
        wr(`CPMC_OFF_XFER, 8'h01);
        cal(1'b1);
        test_done();
    end
endmodule : tb_clock_path_mode_config
`default_nettype wire
